// *** hdl/rials_pkg.sv ***
package rials_pkg;
  localparam int unsigned rials_aw = 8;
  localparam int unsigned rials_dw = 8;
  // register word offsets; byte address is index times four
  localparam logic [7:0] rials_idx_slave_addr = 8'h07;
  localparam logic [7:0] rials_idx_slave_alias = 8'h08;
  localparam logic [7:0] rials_idx_crc_low = 8'h0a;
  localparam logic [7:0] rials_idx_crc_high = 8'h0b;
  localparam logic [7:0] rials_idx_status = 8'h0c;
  localparam logic [7:0] rials_idx_control = 8'h10;
  localparam logic [7:0] rials_idx_irq_status = 8'h11;
  localparam logic [7:0] rials_idx_irq_mask = 8'h12;
  localparam logic [7:0] rials_reset_byte = 8'h00;
  localparam logic [6:0] rials_addr_off = 7'h00;
  localparam logic [15:0] rials_cnt_max = 16'hffff;
  localparam logic [15:0] rials_cnt_one = 16'h0001;
  localparam int unsigned rials_ctl_crc_reset_bit = 5;
  localparam int unsigned rials_ctl_port_sel_bit = 0;
  localparam int unsigned rials_st_bist_bit = 3;
  localparam int unsigned rials_st_pclk_bit = 2;
  localparam int unsigned rials_st_des_bit = 1;
  localparam int unsigned rials_st_link_bit = 0;
  localparam int unsigned rials_nports = 2;
  localparam int unsigned rials_nirq = 4;

  // per-port link events from the control channel
  typedef struct packed {
    logic link_up;
    logic crc_error;
    logic bist_active;
    logic bist_start;
  } rials_link_t;

  // i2c address request and its forwarded form
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } rials_i2c_t;

  typedef struct packed {
    logic hit;
    logic port;
    logic [6:0] addr;
  } rials_fwd_t;
endpackage : rials_pkg

// *** hdl/rials_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module rials_port
  import rials_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rials_link_t link_i,
  input wire logic crc_reset_i,
  output logic [15:0] count_o,
  output logic bist_err_o,
  output logic des_err_o
);
  logic link_d;
  wire link_lost = link_d & ~link_i.link_up;
  wire at_max = (count_o == rials_cnt_max);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= '0;
      bist_err_o <= 1'b0;
      des_err_o <= 1'b0;
      link_d <= 1'b0;
    end else begin
      link_d <= link_i.link_up;
      if (crc_reset_i) begin
        count_o <= '0; // [R05] [R13]
      end else if (link_i.crc_error && !at_max) begin
        count_o <= count_o + rials_cnt_one; // [R04] [R14]
      end
      if (crc_reset_i || link_lost || link_i.bist_start) begin
        bist_err_o <= 1'b0; // [R07]
      end else if (link_i.crc_error && link_i.bist_active) begin
        bist_err_o <= 1'b1; // [R06]
      end
      if (crc_reset_i || link_lost) begin
        des_err_o <= 1'b0; // [R10]
      end else if (link_i.crc_error && !link_i.bist_active) begin
        des_err_o <= 1'b1; // [R10]
      end
    end
  end
endmodule : rials_port
`default_nettype wire

// *** hdl/rials_top.sv ***
// How it works
// R01: an i2c address equal to the alias is forwarded with the stored slave address
// R02: a zero slave address or zero alias disables access to that remote slave
// R03: alias is 7 bits in bits 7:1, bit 0 reserved, compared with incoming addresses
// R04: back-channel crc errors count in 16 bits, low byte at the lower address
// R05: high byte sits at the next address; crc reset control clears the counter
// R06: status bit sets on crc errors while self-test with the far end runs
// R07: self-test error bit clears on link loss, self-test restart or crc reset
// R08: pixel clock bit reads one while a valid pixel clock is present
// R09: pixel clock bit stays set on sudden loss until an invalid clock appears
// R10: normal-mode crc error flag sets on errors, clears on link loss or crc reset
// R11: link detect bit reads one while the cable link is detected
// R12: with second port selected, per-port fields show the second port
// R13: crc reset bit five holds counters clear while set and never self-clears
// R14: counter steps once per crc error and saturates at its maximum
`timescale 1ns/1ps
`default_nettype none
module rials_top
  import rials_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rials_aw-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire rials_link_t link0_i,
  input wire rials_link_t link1_i,
  input wire logic pclk_valid_i,
  input wire logic pclk_invalid_i,
  input wire rials_i2c_t i2c_req_i,
  output rials_fwd_t fwd_o,
  output logic irq_o
);
  logic [6:0] slave_addr [rials_nports];
  logic [6:0] slave_alias [rials_nports];
  logic [7:0] control;
  logic [rials_nirq-1:0] irq_status;
  logic [rials_nirq-1:0] irq_mask;
  logic pclk_det;
  logic [15:0] count [rials_nports];
  logic bist_err [rials_nports];
  logic des_err [rials_nports];
  logic [rials_nirq-1:0] irq_prev;

  wire port_sel = control[rials_ctl_port_sel_bit];
  wire crc_reset = control[rials_ctl_crc_reset_bit];
  wire psel = port_sel;
  wire [7:0] idx = {2'b00, wb_adr_i[rials_aw-1:2]};
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire hit_addr = (idx == rials_idx_slave_addr);
  wire hit_alias = (idx == rials_idx_slave_alias);
  wire hit_low = (idx == rials_idx_crc_low);
  wire hit_high = (idx == rials_idx_crc_high);
  wire hit_stat = (idx == rials_idx_status);
  wire hit_ctl = (idx == rials_idx_control);
  wire hit_ist = (idx == rials_idx_irq_status);
  wire hit_imask = (idx == rials_idx_irq_mask);
  wire mapped = hit_addr | hit_alias | hit_low | hit_high | hit_stat | hit_ctl
                | hit_ist | hit_imask;
  wire rials_link_t link_sel = psel ? link1_i : link0_i;

  // per-port view of all port fields
  wire [6:0] cur_addr = slave_addr[psel]; // [R12]
  wire [6:0] cur_alias = slave_alias[psel]; // [R12]
  wire [15:0] cur_count = count[psel]; // [R12]
  wire [7:0] status_byte = {4'h0, bist_err[psel], pclk_det, des_err[psel],
                            link_sel.link_up}; // [R08] [R11] [R12]
  wire [rials_nirq-1:0] irq_src = {bist_err[psel], des_err[psel], pclk_det,
                                   link_sel.link_up};
  wire [rials_nirq-1:0] irq_evt = irq_src & ~irq_prev;

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = rials_reset_byte;
    if (hit_addr) rd_byte = {cur_addr, 1'b0};
    if (hit_alias) rd_byte = {cur_alias, 1'b0}; // [R03]
    if (hit_low) rd_byte = cur_count[7:0]; // [R04]
    if (hit_high) rd_byte = cur_count[15:8]; // [R05]
    if (hit_stat) rd_byte = status_byte;
    if (hit_ctl) rd_byte = control;
    if (hit_ist) rd_byte = {4'h0, irq_status};
    if (hit_imask) rd_byte = {4'h0, irq_mask};
  end

  // alias match on each port; zero in either field blocks the slave
  wire en0 = (slave_addr[0] != rials_addr_off) && (slave_alias[0] != rials_addr_off); // [R02]
  wire en1 = (slave_addr[1] != rials_addr_off) && (slave_alias[1] != rials_addr_off); // [R02]
  wire m0 = i2c_req_i.valid && en0 && (i2c_req_i.addr == slave_alias[0]); // [R03]
  wire m1 = i2c_req_i.valid && en1 && (i2c_req_i.addr == slave_alias[1]); // [R03]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_o <= '0;
    end else begin
      fwd_o.hit <= m0 | m1;
      fwd_o.port <= ~m0 & m1;
      fwd_o.addr <= m0 ? slave_addr[0] : (m1 ? slave_addr[1] : rials_addr_off); // [R01]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slave_addr[0] <= rials_addr_off;
      slave_addr[1] <= rials_addr_off;
      slave_alias[0] <= rials_addr_off;
      slave_alias[1] <= rials_addr_off;
      control <= rials_reset_byte;
      irq_mask <= '0;
    end else if (wr) begin
      if (hit_addr) slave_addr[psel] <= wb_dat_i[7:1]; // [R12]
      if (hit_alias) slave_alias[psel] <= wb_dat_i[7:1]; // [R03] [R12]
      if (hit_ctl) control <= wb_dat_i[7:0]; // [R13]
      if (hit_imask) irq_mask <= wb_dat_i[rials_nirq-1:0];
    end
  end

  // set wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
      irq_prev <= '0;
    end else begin
      irq_prev <= irq_src;
      irq_status <= (irq_status & ~((wr && hit_ist) ? wb_dat_i[rials_nirq-1:0] : '0))
                    | irq_evt;
    end
  end

  // bit holds through abrupt loss of a valid clock; only an invalid clock drops the bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_det <= 1'b0;
    end else if (pclk_invalid_i) begin
      pclk_det <= 1'b0; // [R09]
    end else if (pclk_valid_i) begin
      pclk_det <= 1'b1; // [R08]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= {24'h000000, rd_byte};
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  rials_port u_port0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .link_i(link0_i),
    .crc_reset_i(crc_reset),
    .count_o(count[0]),
    .bist_err_o(bist_err[0]),
    .des_err_o(des_err[0])
  );

  rials_port u_port1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .link_i(link1_i),
    .crc_reset_i(crc_reset),
    .count_o(count[1]),
    .bist_err_o(bist_err[1]),
    .des_err_o(des_err[1])
  );
endmodule : rials_top
`default_nettype wire

// *** bench/rials_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module rials_top_monitor
  import rials_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rials_aw-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic pclk_invalid_i,
  input wire rials_i2c_t i2c_req_i,
  input wire rials_fwd_t fwd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [5:0] idx = wb_adr_i[7:2];
  wire logic tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire logic map = idx inside {6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h10, 6'h11, 6'h12};
  sequence s_inv;
    pclk_invalid_i [*3];
  endsequence
  sequence s_rdst;
    tk && !wb_we_i && idx == 6'h0c;
  endsequence
  AST_ACK: assert property (tk && map |=> wb_ack_o && !wb_err_o) else $error("no ack");
  AST_ERR: assert property (tk && !map |=> wb_err_o && !wb_ack_o) else $error("no err");
  AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  AST_DATHI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("high data");
  AST_NOREQ: assert property (!i2c_req_i.valid |=> !fwd_o.hit) else $error("stray hit");
  AST_ZERO: assert property (i2c_req_i.valid && i2c_req_i.addr == 7'h00 |=> !fwd_o.hit)
    else $error("zero hit");
  AST_FWDADR: assert property (fwd_o.hit |-> fwd_o.addr != 7'h00) else $error("zero fwd");
  AST_PCLK: assert property (s_inv ##0 s_rdst |=> !wb_dat_o[2]) else $error("pclk set");
endmodule : rials_top_monitor
bind rials_top rials_top_monitor u_mon (.*);
`default_nettype wire

// *** bench/rials_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rials_far_model
  import rials_pkg::*;
(
  input wire logic clk_i,
  output var rials_link_t link_o
);
  initial link_o = '0;
  task automatic set(input rials_link_t v, input int n);
    link_o <= v;
    repeat (n) @(posedge clk_i);
  endtask : set
  // gaps between pulses so each error counts once
  task automatic errs(input int n, input logic b);
    link_o.bist_active <= b;
    repeat (n) begin
      @(posedge clk_i);
      link_o.crc_error <= 1'b1;
      @(posedge clk_i);
      link_o.crc_error <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
  endtask : errs
endmodule : rials_far_model
`default_nettype wire

// *** bench/test_remote_i2c_alias_and_link_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_remote_i2c_alias_and_link_status;
  import rials_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pv = 0, pi = 0, ack, err, irq, e;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, dat_o, q;
  logic [6:0] a, s;
  int fail_count = 0, checks_done = 0, n;
  rials_link_t l0, l1;
  rials_i2c_t i2c = '0;
  rials_fwd_t fwd, fq;
  logic [5:0] n2 [6] = '{6'h07, 6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h12};
  rials_far_model far0 (.clk_i(clk_i), .link_o(l0));
  rials_far_model far1 (.clk_i(clk_i), .link_o(l1));
  rials_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .link0_i(l0), .link1_i(l1), .pclk_valid_i(pv), .pclk_invalid_i(pi),
    .i2c_req_i(i2c), .fwd_o(fwd), .irq_o(irq));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [7:0] st(input logic b, p, d, l);
    return {4'h0, b, p, d, l};
  endfunction : st
  task automatic test_done;
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, i, 2'b00, 4'hf, 24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
    q = dat_o;
    e = err;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    wb(1'b0, i, 8'h00);
    chk(q, {24'h0, x});
  endtask : rd
  task automatic req(input logic [6:0] ad);
    @(posedge clk_i);
    i2c <= {1'b1, ad};
    @(posedge clk_i);
    i2c <= '0;
    // forwarded word stands one cycle; take it mid-cycle, away from the edge
    @(negedge clk_i);
    fq = fwd;
    @(posedge clk_i);
  endtask : req
  task automatic pclk(input logic v, i);
    {pv, pi} <= {v, i};
    repeat (3) @(posedge clk_i);
  endtask : pclk
  initial begin
    n = $urandom(32'h9612);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (n2[k]) rd(n2[k], 8'h00);
    wb(1'b0, 6'h3f, 8'h00);
    chk({31'h0, e}, 32'h1);
    a = 7'($urandom_range(1, 127));
    s = 7'($urandom_range(1, 127));
    wb(1'b1, 6'h07, {s, 1'b1});
    wb(1'b1, 6'h08, {a, 1'b1});
    rd(6'h07, {s, 1'b0});
    rd(6'h08, {a, 1'b0});
    req(a);
    chk({23'h0, fq}, {23'h0, 2'b10, s});
    req(7'h00);
    chk({31'h0, fq.hit}, 32'h0);
    wb(1'b1, 6'h07, 8'h00);
    req(a);
    chk({31'h0, fq.hit}, 32'h0);
    n = $urandom_range(2, 20);
    far0.set(4'b1000, 3);
    far0.errs(n, 1'b0);
    rd(6'h0a, 8'(n));
    rd(6'h0b, 8'h00);
    rd(6'h0c, st(0, 0, 1, 1));
    wb(1'b1, 6'h10, 8'h20);
    far0.errs(3, 1'b0);
    rd(6'h0a, 8'h00);
    rd(6'h0c, st(0, 0, 0, 1));
    wb(1'b1, 6'h10, 8'h00);
    far0.errs(1, 1'b0);
    rd(6'h0a, 8'h01);
    far0.errs(1, 1'b1);
    rd(6'h0c, st(1, 0, 1, 1));
    far0.set(4'b1011, 1);
    far0.set(4'b1010, 3);
    rd(6'h0c, st(0, 0, 1, 1));
    far0.errs(1, 1'b1);
    far0.set(4'b0000, 3);
    rd(6'h0c, st(0, 0, 0, 0));
    n = $urandom_range(1, 9);
    far1.set(4'b1000, 3);
    far1.errs(n, 1'b0);
    wb(1'b1, 6'h10, 8'h01);
    rd(6'h0a, 8'(n));
    rd(6'h0c, st(0, 0, 1, 1));
    wb(1'b1, 6'h10, 8'h00);
    pclk(1'b1, 1'b0);
    rd(6'h0c, st(0, 1, 0, 0));
    pclk(1'b0, 1'b0);
    rd(6'h0c, st(0, 1, 0, 0));
    pclk(1'b0, 1'b1);
    rd(6'h0c, st(0, 0, 0, 0));
    pclk(1'b0, 1'b0);
    wb(1'b1, 6'h12, 8'h01);
    wb(1'b1, 6'h11, 8'hff);
    chk({31'h0, irq}, 32'h0);
    far0.set(4'b1000, 3);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 6'h12, 8'h00);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 6'h11, 8'h01);
    rd(6'h11, 8'h00);
    far1.set(4'b1100, 66000);
    far1.set(4'b1000, 3);
    wb(1'b1, 6'h10, 8'h01);
    rd(6'h0a, 8'hff);
    rd(6'h0b, 8'hff);
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
endmodule : test_remote_i2c_alias_and_link_status
`default_nettype wire
